// ==== hw/dctr_pkg.sv ====
// Purpose: shared constants and carrier types for the compare and trace register front end
// Assumes: byte-wide register port, one 10 MHz clock
// Notes:   register indices are byte offsets from the block base
package dctr_pkg;

  // ************************************************************
  // register map (byte index within the nine-byte window)
  // ************************************************************
  localparam logic [3:0] REG_CMP_A_UPPER  = 4'h0;
  localparam logic [3:0] REG_CMP_A_LOWER  = 4'h1;
  localparam logic [3:0] REG_CMP_B_UPPER  = 4'h2;
  localparam logic [3:0] REG_CMP_B_LOWER  = 4'h3;
  localparam logic [3:0] REG_FIFO_UPPER   = 4'h4;
  localparam logic [3:0] REG_FIFO_LOWER   = 4'h5;
  localparam logic [3:0] REG_CONTROL      = 4'h6;
  localparam logic [3:0] REG_TRIG_SETUP   = 4'h7;
  localparam logic [3:0] REG_STATUS       = 4'h8;

  // ************************************************************
  // control bit positions and reset values
  // ************************************************************
  localparam int CTL_ENABLE   = 7;
  localparam int CTL_ARM      = 6;
  localparam int CTL_TAG      = 5;
  localparam int CTL_BREAK_REQUEST_ENABLE    = 4;
  localparam int CTL_RWA      = 3;
  localparam int CTL_CMP_A_DIRECTION_QUALIFY    = 2;
  localparam int CTL_RWB      = 1;
  localparam int CTL_CMP_B_DIRECTION_QUALIFY    = 0;
  localparam logic [7:0] CMP_RESET  = 8'h00;
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [7:0] READ_ZERO  = 8'h00;

  // ************************************************************
  // trigger modes
  // ************************************************************
  localparam logic [3:0] TRG_A_ONLY     = 4'h0;
  localparam logic [3:0] TRG_A_OR_B     = 4'h1;
  localparam logic [3:0] TRG_A_THEN_B   = 4'h2;
  localparam logic [3:0] TRG_EVENT_B    = 4'h3;
  localparam logic [3:0] TRG_A_EVENT_B  = 4'h4;
  localparam logic [3:0] TRG_A_AND_B    = 4'h5;
  localparam logic [3:0] TRG_A_NOT_B    = 4'h6;
  localparam logic [3:0] TRG_INSIDE     = 4'h7;
  localparam logic [3:0] TRG_OUTSIDE    = 4'h8;

  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int BUF_DEPTH  = 16;

  // cpu bus cycle as seen by the comparators
  typedef struct packed {
    logic        valid;
    logic        read;
    logic [15:0] addr;
    logic [7:0]  data;
  } dctr_cpu_t;

  // register port request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dctr_reg_req_t;

  typedef enum logic [2:0] {
    RUN_IDLE  = 3'b001,
    RUN_WAITB = 3'b010,
    RUN_STORE = 3'b100
  } dctr_run_t;

endpackage

// ==== hw/dctr_buf.sv ====
// Purpose: valid/ready buffer in front of the trace capture path
// Assumes: single clock, asynchronous active-high reset
// Notes:   show-ahead output, full and empty are exact
`timescale 1ns/1ps
module dctr_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // flags follow the occupancy count
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // storage array, no reset needed
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + AW'(1);
      if (pop)  rd_ptr <= rd_ptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== hw/dctr_top.sv ====
// Purpose: register front end of the bus compare and trace unit
// Assumes: byte register port synchronous to sys_clk, one request per cycle
// Notes:   read data is registered and valid the cycle after rd
`timescale 1ns/1ps
module dctr_top
  import dctr_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire dctr_pkg::dctr_reg_req_t reg_req,
  output logic [7:0]                   reg_rdata,
  input  wire dctr_pkg::dctr_cpu_t     cpu_bus,
  input  wire logic [15:0]             last_opcode_addr,
  input  wire logic                    opcode_executed,
  input  wire logic                    secure,
  output logic                         break_force,
  output logic                         break_tag,
  output logic                         capture_active_flag,
  output logic                         buf_stall
);
  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0]      comparator_a_upper;
  logic [7:0]      comparator_a_lower;
  logic [7:0]      comparator_b_upper;
  logic [7:0]      comparator_b_lower;
  logic [7:0]      trace_control;
  logic [7:0]      trigger_setup;
  logic [15:0]     fifo [FIFO_DEPTH];
  logic [3:0]      valid_count;
  logic            flag_a;
  logic            flag_b;
  dctr_run_t       run_state;
  logic            trig_seen;

  // ************************************************************
  // decode
  // ************************************************************
  wire unit_enable                 = trace_control[CTL_ENABLE];
  wire armed                       = trace_control[CTL_ARM];
  wire break_request_enable        = trace_control[CTL_BREAK_REQUEST_ENABLE];
  wire cmp_a_direction             = trace_control[CTL_RWA];
  wire cmp_a_direction_qualify     = trace_control[CTL_CMP_A_DIRECTION_QUALIFY];
  wire cmp_b_direction             = trace_control[CTL_RWB];
  wire cmp_b_direction_qualify     = trace_control[CTL_CMP_B_DIRECTION_QUALIFY];
  wire execute_qualify_select      = trigger_setup[7];
  wire begin_sel                   = trigger_setup[6];
  wire [3:0] trig_mode             = trigger_setup[3:0];
  wire wr_ctl    = reg_req.wr && (reg_req.addr == REG_CONTROL);
  wire wr_cmp_ok = reg_req.wr && !armed;
  wire wr_trg_ok = reg_req.wr && !armed && (reg_req.addr == REG_TRIG_SETUP);
  wire rd_low    = reg_req.rd && (reg_req.addr == REG_FIFO_LOWER);
  wire event_only = (trig_mode == TRG_EVENT_B) || (trig_mode == TRG_A_EVENT_B);
  wire begin_trace = begin_sel || event_only;

  // direction-qualified address match, used for both comparators
  function automatic logic cmp_match(input logic [15:0] ref_addr, input logic qual,
                                     input logic dir, input dctr_cpu_t bus);
    cmp_match = bus.valid && (bus.addr == ref_addr) && (!qual || (bus.read == dir));
  endfunction

  wire [15:0] cmp_a_value = {comparator_a_upper, comparator_a_lower};
  wire [15:0] cmp_b_value = {comparator_b_upper, comparator_b_lower};
  wire watching = unit_enable && armed;
  wire match_a  = watching && cmp_match(cmp_a_value, cmp_a_direction_qualify,
                                        cmp_a_direction, cpu_bus);
  wire match_b  = watching && cmp_match(cmp_b_value, cmp_b_direction_qualify,
                                        cmp_b_direction, cpu_bus);
  wire in_range = watching && cpu_bus.valid && (cpu_bus.addr >= cmp_a_value)
                  && (cpu_bus.addr <= cmp_b_value);
  wire qual_ok  = !execute_qualify_select || opcode_executed;

  // trigger selection per mode; data modes compare b against data byte
  logic trig_now;
  always_comb begin
    trig_now = 1'b0;
    unique case (trig_mode)
      TRG_A_ONLY:    trig_now = match_a;
      TRG_A_OR_B:    trig_now = match_a || match_b;
      TRG_A_THEN_B:  trig_now = match_b && (flag_a || trig_seen);
      TRG_EVENT_B:   trig_now = match_b;
      TRG_A_EVENT_B: trig_now = match_b && flag_a;
      TRG_A_AND_B:   trig_now = match_a && (cpu_bus.data == comparator_b_lower);
      TRG_A_NOT_B:   trig_now = match_a && (cpu_bus.data != comparator_b_lower);
      TRG_INSIDE:    trig_now = in_range;
      TRG_OUTSIDE:   trig_now = watching && cpu_bus.valid && !in_range;
      default:       trig_now = 1'b0;
    endcase
  end
  wire trigger = trig_now && qual_ok;

  // ************************************************************
  // capture buffer in the data path
  // ************************************************************
  wire [15:0] cap_word = event_only ? {8'h00, cpu_bus.data} : cpu_bus.addr;
  wire        storing  = (run_state == RUN_STORE) ||
                         (watching && !begin_trace);
  wire        cap_valid = storing && cpu_bus.valid && (!event_only || match_b);
  wire        cap_ready;
  wire        drain_valid;
  wire [15:0] drain_data;
  wire        full_now = (valid_count == 4'(FIFO_DEPTH));
  wire        fifo_full_event = begin_trace && full_now && (run_state == RUN_STORE);
  wire        run_end = (begin_trace && fifo_full_event) ||
                        (!begin_trace && watching && trigger);

  dctr_buf #(.WIDTH(FIFO_WIDTH), .DEPTH(BUF_DEPTH)) u_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .flush     (!watching),
    .in_valid  (cap_valid),
    .in_ready  (cap_ready),
    .in_data   (cap_word),
    .out_valid (drain_valid),
    .out_ready (1'b1),
    .out_data  (drain_data)
  );

  // shift fifo: captured words enter last slot, lower reads shift out only while disarmed
  wire shift_cap  = drain_valid;
  wire shift_read = rd_low && !armed;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < FIFO_DEPTH; i++) fifo[i] <= 16'h0000;
    end else if (shift_read) begin
      for (int i = 0; i < FIFO_DEPTH-1; i++) fifo[i] <= fifo[i+1];
      fifo[FIFO_DEPTH-1] <= last_opcode_addr;
    end else if (shift_cap && (!begin_trace || !full_now)) begin
      for (int i = 0; i < FIFO_DEPTH-1; i++) fifo[i] <= fifo[i+1];
      fifo[FIFO_DEPTH-1] <= drain_data;
    end
  end

  // valid count clears when a run starts
  wire arm_write = wr_ctl && reg_req.wdata[CTL_ARM] && !armed;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      valid_count <= 4'h0;
    end else if (arm_write) begin
      valid_count <= 4'h0;
    end else if (watching && shift_cap && !full_now) begin
      valid_count <= valid_count + 4'h1;
    end
  end

  // ************************************************************
  // run sequencing
  // ************************************************************
  dctr_run_t next_run;
  always_comb begin
    next_run = run_state;
    unique case (run_state)
      RUN_IDLE:  if (watching && begin_trace && trigger) next_run = RUN_STORE;
      RUN_WAITB: next_run = RUN_IDLE;
      RUN_STORE: if (fifo_full_event) next_run = RUN_IDLE;
      default:   next_run = RUN_IDLE;
    endcase
    if (!watching) next_run = RUN_IDLE;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_state <= RUN_IDLE;
      trig_seen <= 1'b0;
      flag_a    <= 1'b0;
      flag_b    <= 1'b0;
    end else begin
      run_state <= next_run;
      trig_seen <= arm_write ? 1'b0 : (trig_seen || (match_a && qual_ok));
      flag_a    <= arm_write ? 1'b0 : (flag_a || match_a);
      flag_b    <= arm_write ? 1'b0 : (flag_b || match_b);
    end
  end

  // ************************************************************
  // control and comparator registers
  // ************************************************************
  // control write: enable refused when secured, run end clears arm
  logic [7:0] next_control;
  always_comb begin
    next_control = trace_control;
    if (wr_ctl) begin
      next_control = reg_req.wdata;
      if (secure && !trace_control[CTL_ENABLE]) next_control[CTL_ENABLE] = 1'b0;
      if (!next_control[CTL_ENABLE]) next_control[CTL_ARM] = 1'b0;
    end else if (run_end) begin
      next_control[CTL_ARM] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trace_control       <= CTL_RESET;
      trigger_setup       <= CTL_RESET;
      comparator_a_upper  <= CMP_RESET;
      comparator_a_lower  <= CMP_RESET;
      comparator_b_upper  <= CMP_RESET;
      comparator_b_lower  <= CMP_RESET;
    end else begin
      trace_control <= next_control;
      if (wr_trg_ok) trigger_setup <= reg_req.wdata & 8'hcf;
      if (wr_cmp_ok && reg_req.addr == REG_CMP_A_UPPER) comparator_a_upper <= reg_req.wdata;
      if (wr_cmp_ok && reg_req.addr == REG_CMP_A_LOWER) comparator_a_lower <= reg_req.wdata;
      if (wr_cmp_ok && reg_req.addr == REG_CMP_B_UPPER) comparator_b_upper <= reg_req.wdata;
      if (wr_cmp_ok && reg_req.addr == REG_CMP_B_LOWER) comparator_b_lower <= reg_req.wdata;
      // fifo port writes fall through with no effect
    end
  end

  // ************************************************************
  // read mux and outputs
  // ************************************************************
  wire [7:0] status_byte = {flag_a, flag_b, armed && unit_enable, 1'b0, valid_count};
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = READ_ZERO;
    unique case (reg_req.addr)
      REG_CMP_A_UPPER: rd_mux = comparator_a_upper;
      REG_CMP_A_LOWER: rd_mux = comparator_a_lower;
      REG_CMP_B_UPPER: rd_mux = comparator_b_upper;
      REG_CMP_B_LOWER: rd_mux = comparator_b_lower;
      REG_FIFO_UPPER:  rd_mux = event_only ? READ_ZERO : fifo[0][15:8];
      REG_FIFO_LOWER:  rd_mux = fifo[0][7:0];
      REG_CONTROL:     rd_mux = trace_control;
      REG_TRIG_SETUP:  rd_mux = trigger_setup;
      REG_STATUS:      rd_mux = status_byte;
      default:         rd_mux = READ_ZERO;
    endcase
  end

  // break type chosen by tag bit; timing follows execute qualify through the trigger
  wire brk_evt = break_request_enable && run_end;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata           <= READ_ZERO;
      break_force         <= 1'b0;
      break_tag           <= 1'b0;
      capture_active_flag <= 1'b0;
      buf_stall           <= 1'b0;
    end else begin
      if (reg_req.rd) reg_rdata <= rd_mux;
      break_force         <= brk_evt && !trace_control[CTL_TAG];
      break_tag           <= brk_evt && trace_control[CTL_TAG];
      capture_active_flag <= next_control[CTL_ARM] && next_control[CTL_ENABLE];
      buf_stall           <= cap_valid && !cap_ready;
    end
  end
endmodule

// ==== verif/dctr_top_chk.sv ====
// Purpose: port-level checks for the compare and trace register front end
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   trigger mode is shadowed from register writes
`timescale 1ns/1ps
module dctr_top_chk
  import dctr_pkg::*;
(
  input wire logic                    sys_clk,
  input wire logic                    rst,
  input wire dctr_pkg::dctr_reg_req_t reg_req,
  input wire logic [7:0]              reg_rdata,
  input wire dctr_pkg::dctr_cpu_t     cpu_bus,
  input wire logic [15:0]             last_opcode_addr,
  input wire logic                    opcode_executed,
  input wire logic                    secure,
  input wire logic                    break_force,
  input wire logic                    break_tag,
  input wire logic                    capture_active_flag,
  input wire logic                    buf_stall
);
  // ************************************************************
  // helpers and checks
  // ************************************************************
  logic [3:0] mode;
  logic       wr6;
  // control write decode shared by several checks
  assign wr6 = reg_req.wr && reg_req.addr == REG_CONTROL;
  // shadow of trigger mode; armed writes are refused so skip them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) mode <= 4'h0;
    else if (reg_req.wr && reg_req.addr == REG_TRIG_SETUP && !capture_active_flag)
      mode <= reg_req.wdata[3:0];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_rdata_holds:
    assert property (!reg_req.rd |=> $stable(reg_rdata)) else $error("read data moved");
  a_arm_sets:
    assert property (wr6 && reg_req.wdata[7:6] == 2'b11 && !secure |=> capture_active_flag)
      else $error("arm write did not arm");
  a_arm_clear_stops:
    assert property (wr6 && !reg_req.wdata[6] |=> !capture_active_flag)
      else $error("arm clear left run going");
  a_enable_clear_stops:
    assert property (wr6 && !reg_req.wdata[7] |=> !capture_active_flag)
      else $error("enable clear left run going");
  a_ctl_readback:
    assert property (wr6 && !reg_req.wdata[7] ##2 (reg_req.rd && reg_req.addr == REG_CONTROL)
      |=> reg_rdata == ($past(reg_req.wdata, 3) & 8'hbf)) else $error("control readback wrong");
  a_break_excl:
    assert property (break_force |-> !break_tag) else $error("both break types at once");
  a_break_from_run:
    assert property (break_force || break_tag |-> $past(capture_active_flag))
      else $error("break without armed run");
  a_break_pulse:
    assert property (break_tag |=> !break_tag) else $error("tag break longer than a cycle");
  a_upper_zero:
    assert property (reg_req.rd && reg_req.addr == REG_FIFO_UPPER && mode inside {4'h3, 4'h4}
      |=> reg_rdata == 8'h00) else $error("fifo upper not zero in event mode");
  c_force: cover property (break_force);
  c_tag: cover property (break_tag);
  c_armed: cover property ($rose(capture_active_flag));
endmodule

bind dctr_top dctr_top_chk chk_u (
  .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .cpu_bus(cpu_bus), .last_opcode_addr(last_opcode_addr), .opcode_executed(opcode_executed),
  .secure(secure), .break_force(break_force), .break_tag(break_tag),
  .capture_active_flag(capture_active_flag), .buf_stall(buf_stall));

// ==== verif/dctr_cpu_model.sv ====
// Purpose: cpu core bus model facing the comparators
// Assumes: one bus cycle per go pulse
// Notes:   read cycles count as opcode fetches
`timescale 1ns/1ps
module dctr_cpu_model
  import dctr_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          go,
  input  wire logic          go_read,
  input  wire logic [15:0]   go_addr,
  output dctr_pkg::dctr_cpu_t cpu_bus,
  output logic [15:0]        last_opcode_addr,
  output logic               opcode_executed
);
  // ************************************************************
  // bus cycles
  // ************************************************************
  // idle bus shows inverted junk so a stale address never matches by luck
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cpu_bus <= '0;
      last_opcode_addr <= 16'h0000;
      opcode_executed <= 1'b0;
    end else if (go) begin
      cpu_bus <= '{valid: 1'b1, read: go_read, addr: go_addr, data: go_addr[7:0]};
      if (go_read) last_opcode_addr <= go_addr;
      opcode_executed <= go_read;
    end else begin
      cpu_bus <= '{valid: 1'b0, read: ~cpu_bus.read, addr: ~cpu_bus.addr, data: ~cpu_bus.data};
      opcode_executed <= 1'b0;
    end
  end
endmodule

// ==== verif/dctr_top_tb_top.sv ====
// Purpose: self-checking bench for the register front end
// Assumes: 10 MHz clock, one register access per two cycles
// Notes:   table rows first, then profiling, arming, secure, break, event and reset cases
`timescale 1ns/1ps
module dctr_top_tb_top;
  import dctr_pkg::*;
  typedef struct packed {
    logic       wr;
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } dctr_row_t;
  logic            sys_clk = 1'b0;
  logic            rst = 1'b1;
  logic            secure = 1'b0;
  logic            go = 1'b0;
  logic            go_read = 1'b0;
  logic [15:0]     go_addr = 16'h0000;
  dctr_reg_req_t   reg_req = '0;
  dctr_cpu_t       cpu_bus;
  logic [7:0]      reg_rdata, seen;
  logic [15:0]     last_opcode_addr, ev;
  logic            opcode_executed, break_force, break_tag, capture_active_flag, buf_stall;
  int              fails = 0, n_compared = 0, nf = 0, nt = 0;
  dctr_row_t rows [21] = '{'{0,0,0,0}, '{0,1,0,0}, '{0,2,0,0}, '{0,3,0,0},
    '{1,0,8'h12,0}, '{1,1,8'h34,0}, '{1,2,8'h56,0}, '{1,3,8'h78,0}, '{1,4,8'haa,0},
    '{1,5,8'hbb,0}, '{0,0,0,8'h12}, '{0,1,0,8'h34}, '{0,2,0,8'h56}, '{0,3,0,8'h78},
    '{0,9,0,0}, '{1,6,8'h0f,0}, '{0,6,0,8'h0f}, '{1,7,8'h03,0}, '{0,4,0,0},
    '{1,7,0,0}, '{1,6,0,0}};
  dctr_top dut_u (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .cpu_bus(cpu_bus), .last_opcode_addr(last_opcode_addr), .opcode_executed(opcode_executed),
    .secure(secure), .break_force(break_force), .break_tag(break_tag),
    .capture_active_flag(capture_active_flag), .buf_stall(buf_stall));
  dctr_cpu_model partner_u (.sys_clk(sys_clk), .rst(rst), .go(go), .go_read(go_read),
    .go_addr(go_addr), .cpu_bus(cpu_bus), .last_opcode_addr(last_opcode_addr),
    .opcode_executed(opcode_executed));
  // ************************************************************
  // clock, break counters and tasks
  // ************************************************************
  always #50 sys_clk = ~sys_clk;
  // pulses last one cycle, so one sample per edge counts each once
  always @(posedge sys_clk) begin
    if (break_force === 1'b1) nf++;
    if (break_tag === 1'b1) nt++;
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      fails++;
    end
  endtask
  // request held one cycle, read data taken after it settles
  task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge sys_clk);
    reg_req <= '0;
    @(negedge sys_clk);
    seen = reg_rdata;
  endtask
  task bus(input logic r, input logic [15:0] a);
    @(posedge sys_clk);
    go <= 1'b1;
    go_read <= r;
    go_addr <= a;
    @(posedge sys_clk);
    go <= 1'b0;
  endtask
  function automatic logic [15:0] pv(input int k);
    return 16'h3c00 ^ (16'(k) * 16'h0107);
  endfunction
  task complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    complete_run();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      acc(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(seen, rows[i].e);
    end
    $display("table done");
    // profiling: each lower read returns the fetch stored eight reads ago
    for (int k = 0; k < 16; k++) begin
      bus(1'b1, pv(k));
      ev = pv(k - 8);
      acc(1'b0, REG_FIFO_UPPER, 8'h00);
      if (k >= 8) chk(seen, ev[15:8]);
      acc(1'b0, REG_FIFO_UPPER, 8'h00);
      if (k >= 8) chk(seen, ev[15:8]);
      acc(1'b0, REG_FIFO_LOWER, 8'h00);
      if (k >= 8) chk(seen, ev[7:0]);
    end
    $display("profiling done");
    ev = pv(8);
    acc(1'b1, REG_CONTROL, 8'hc0);
    chk({7'h00, capture_active_flag}, 8'h01);
    acc(1'b1, REG_CMP_A_UPPER, 8'hff);
    acc(1'b0, REG_CMP_A_UPPER, 8'h00);
    chk(seen, 8'h12);
    acc(1'b0, REG_CONTROL, 8'h00);
    chk(seen, 8'hc0);
    acc(1'b0, REG_FIFO_LOWER, 8'h00);
    chk(seen, ev[7:0]);
    acc(1'b0, REG_FIFO_UPPER, 8'h00);
    chk(seen, ev[15:8]);
    acc(1'b1, REG_CONTROL, 8'h80);
    chk({7'h00, capture_active_flag}, 8'h00);
    acc(1'b1, REG_CONTROL, 8'hc0);
    acc(1'b1, REG_CONTROL, 8'h40);
    chk({7'h00, capture_active_flag}, 8'h00);
    $display("arming done");
    acc(1'b1, REG_CONTROL, 8'h00);
    @(posedge sys_clk);
    secure <= 1'b1;
    acc(1'b1, REG_CONTROL, 8'h80);
    acc(1'b0, REG_CONTROL, 8'h00);
    chk(seen, 8'h00);
    @(posedge sys_clk);
    secure <= 1'b0;
    $display("secure done");
    // wrong direction first, then the qualifying one ends the run
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, REG_CONTROL, (i != 0) ? 8'hfc : 8'hd4);
      bus(i == 0, 16'h1234);
      repeat (6) @(posedge sys_clk);
      chk(8'(nf + nt), 8'(i));
      bus(i != 0, 16'h1234);
      for (int n = 0; n < 10 && capture_active_flag === 1'b1; n++) @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
      chk(8'(nf), 8'h01);
      chk(8'(nt), 8'(i));
      chk({7'h00, capture_active_flag}, 8'h00);
    end
    $display("break done");
    // event-only b: fifo head still holds an address, so upper must be masked
    acc(1'b1, REG_TRIG_SETUP, 8'h03);
    acc(1'b0, REG_FIFO_UPPER, 8'h00);
    chk(seen, 8'h00);
    // begin trace: first match starts the run, eight more fill the fifo
    acc(1'b1, REG_CONTROL, 8'hd0);
    for (int j = 0; j < 9; j++) bus(1'b0, 16'h5678);
    repeat (8) @(posedge sys_clk);
    chk({7'h00, capture_active_flag}, 8'h00);
    chk(8'(nf), 8'h02);
    chk({7'h00, buf_stall}, 8'h00);
    // back to an address mode so the upper half of each word is visible
    acc(1'b1, REG_TRIG_SETUP, 8'h00);
    for (int j = 0; j < 8; j++) begin
      acc(1'b0, REG_FIFO_UPPER, 8'h00);
      chk(seen, 8'h00);
      acc(1'b0, REG_FIFO_LOWER, 8'h00);
      chk(seen, 8'h78);
    end
    $display("event done");
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      acc(1'b0, 4'(a), 8'h00);
      chk(seen, 8'h00);
    end
    $display("reset done");
    complete_run();
  end
endmodule
